// ### core/sec_pkg.sv
// Constants shared by the serial memory host controller
package sec_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCK_HALF_NS   = 250;
    localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_GAP_NS     = 500;
    localparam int CS_GAP_CYC    = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int ADDR_W    = 13;
    localparam int ADDR_PAD  = 16 - ADDR_W;
    localparam int BUF_DEPTH = 32;
    localparam int PTR_W     = 5;
    localparam int LEN_W     = 6;

    localparam logic [7:0] OP_READ       = 8'h03;
    localparam logic [7:0] OP_WRITE      = 8'h02;
    localparam logic [7:0] OP_LATCH_SET  = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR  = 8'h04;
    localparam logic [7:0] OP_STATUS_RD  = 8'h05;
    localparam logic [7:0] OP_STATUS_WR  = 8'h01;

    localparam logic [2:0] CMD_READ      = 3'h0;
    localparam logic [2:0] CMD_WRITE     = 3'h1;
    localparam logic [2:0] CMD_LATCH_SET = 3'h2;
    localparam logic [2:0] CMD_LATCH_CLR = 3'h3;
    localparam logic [2:0] CMD_STAT_RD   = 3'h4;
    localparam logic [2:0] CMD_STAT_WR   = 3'h5;

    localparam int DEV_BUSY_BIT = 0;
    localparam int DEV_LATCH_BIT = 1;
    localparam int DEV_BPL_BIT  = 2;
    localparam int DEV_BPH_BIT  = 3;
    localparam int DEV_PPE_BIT  = 7;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_LEN  = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_DATA = 8'h10;
    localparam logic [7:0] REG_PINS = 8'h14;

    localparam int CTRL_GO_BIT   = 8;
    localparam int CTRL_POLL_BIT = 9;
    localparam int PINS_PAUSE_BIT = 0;
    localparam int PINS_WP_BIT    = 1;

    localparam logic [LEN_W-1:0] LEN_RST       = 6'h01;
    localparam logic             WP_RST        = 1'b1;
    localparam logic [2:0]       MISO_SYNC_RST = 3'h7;
endpackage : sec_pkg

// ### core/sec_link_if.sv
// Byte-level link between the command sequencer and the bit engine
interface sec_link_if;
    logic       start;
    logic       last;
    logic [7:0] tx;
    logic       pause_req;
    logic       miso_f;
    logic [7:0] rx;
    logic       done;
    logic       idle;
    logic       cs_n;
    logic       sck;
    logic       mosi;
    logic       hold_n;
    modport eng (input start, last, tx, pause_req, miso_f,
                 output rx, done, idle, cs_n, sck, mosi, hold_n);
    modport ctl (output start, last, tx, pause_req, miso_f,
                 input rx, done, idle, cs_n, sck, mosi, hold_n);
endinterface : sec_link_if

// ### core/sec_shifter.sv
// Serial bit engine: clock divider, shifting, chip select and pause pin
module sec_shifter
    import sec_pkg::*;
#(
    parameter int HALF_CYC = SCK_HALF_CYC,
    parameter int GAP_CYC  = CS_GAP_CYC
)
(
    input wire logic core_clk,
    input wire logic rst,
    sec_link_if.eng  lk
);
    localparam int CW = $clog2(GAP_CYC + HALF_CYC + 1);
    typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_PAUSE, ST_END, ST_GAP} sec_bit_e;

    sec_bit_e      st;
    logic [CW-1:0] cnt;
    logic [2:0]    bitc;
    logic [7:0]    shreg;
    logic [7:0]    rxsh;
    logic          last_q;
    wire           half_end = (cnt == CW'(HALF_CYC - 1));
    wire           gap_end  = (cnt == CW'(GAP_CYC - 1));

    assign lk.idle = (st == ST_IDLE);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st        <= ST_IDLE;
            cnt       <= '0;
            bitc      <= 3'h7;
            shreg     <= 8'h00;
            rxsh      <= 8'h00;
            last_q    <= 1'b0;
            lk.rx     <= 8'h00;
            lk.done   <= 1'b0;
            lk.cs_n   <= 1'b1;
            lk.sck    <= 1'b0;
            lk.mosi   <= 1'b0;
            lk.hold_n <= 1'b1;
        end
        else
        begin
            lk.done <= 1'b0;
            cnt     <= cnt + 1'b1;
            unique case (st)
            ST_IDLE:
                if (lk.start)
                begin
                    lk.cs_n <= 1'b0;
                    lk.mosi <= lk.tx[7];
                    shreg   <= lk.tx;
                    last_q  <= lk.last;
                    bitc    <= 3'h7;
                    cnt     <= '0;
                    st      <= ST_LOW;
                end
            ST_LOW:
                if (half_end)
                begin
                    cnt <= '0;
                    // Pause only ever entered with the clock low
                    if (lk.pause_req)
                    begin
                        lk.hold_n <= 1'b0;
                        st        <= ST_PAUSE;
                    end
                    else
                    begin
                        lk.sck <= 1'b1;
                        rxsh   <= {rxsh[6:0], lk.miso_f};
                        st     <= ST_HIGH;
                    end
                end
            ST_HIGH:
                if (half_end)
                begin
                    cnt    <= '0;
                    lk.sck <= 1'b0;
                    if (bitc != 3'h0)
                    begin
                        bitc    <= bitc - 1'b1;
                        shreg   <= {shreg[6:0], 1'b0};
                        lk.mosi <= shreg[6];
                        st      <= ST_LOW;
                    end
                    else
                    begin
                        lk.rx <= rxsh;
                        if (last_q)
                            st <= ST_END;
                        else
                        begin
                            lk.done <= 1'b1;
                            st      <= ST_IDLE;
                        end
                    end
                end
            ST_PAUSE:
            begin
                // Clock, data and select frozen; bit position kept
                cnt <= '0;
                if (!lk.pause_req)
                begin
                    lk.hold_n <= 1'b1;
                    st        <= ST_LOW;
                end
            end
            ST_END:
                if (half_end)
                begin
                    cnt     <= '0;
                    lk.cs_n <= 1'b1;
                    st      <= ST_GAP;
                end
            ST_GAP:
                if (gap_end)
                begin
                    lk.done <= 1'b1;
                    st      <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : sec_shifter

// ### core/sec_host.sv
// Host controller for a serial nonvolatile memory, commanded over Avalon-MM
// Operation
// - Pause pin stays high unless pausing
// - Pause asserted only while serial clock low
// - While paused, select held and link frozen
// - Pause released only while serial clock low
// - Select low, pause high across operation
// - Eight-bit instruction; everything MSB first
// - Read opcode, 16-bit address, top three zero
// - Read ends when select is raised
// - Latch set alone in its selection
// - Write carries 1..32 bytes in page
// - Select rises right after last data bit
// - Latch clear and status opcodes encoded
module sec_host
    import sec_pkg::*;
#(
    parameter int HALF_CYC = SCK_HALF_CYC,
    parameter int GAP_CYC  = CS_GAP_CYC
)
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  av_address,
    input  wire logic        av_read,
    input  wire logic        av_write,
    input  wire logic [31:0] av_writedata,
    output logic      [31:0] av_readdata,
    output logic             av_waitrequest,
    output logic             spi_cs_n,
    output logic             spi_sck,
    output logic             spi_mosi,
    input  wire logic        spi_miso,
    output logic             spi_hold_n,
    output logic             spi_wp_n
);
    typedef enum logic [2:0] {M_IDLE, M_OPC, M_ADDH, M_ADDL, M_DATA} sec_seq_e;

    sec_link_if lk ();

    sec_shifter #(
        .HALF_CYC (HALF_CYC),
        .GAP_CYC  (GAP_CYC)
    ) u_shifter (
        .core_clk (core_clk),
        .rst      (rst),
        .lk       (lk.eng)
    );

    sec_seq_e          state;
    logic [2:0]        cmd_r;
    logic [ADDR_W-1:0] addr_r;
    logic [LEN_W-1:0]  len_r;
    logic [LEN_W-1:0]  nbyte;
    logic [PTR_W-1:0]  wptr;
    logic [PTR_W-1:0]  rptr;
    logic [7:0]        stat_byte;
    logic [7:0]        buf_mem [0:BUF_DEPTH-1];
    logic [2:0]        miso_sync;
    logic              miso_f;
    logic              start;
    logic              err;
    logic              poll_en;
    logic              polling;
    logic              pause_r;
    logic              wp_r;

    // Select, clock, data and pause pins come straight from the engine's flops; write protect from wp_r
    assign spi_cs_n   = lk.cs_n;
    assign spi_sck    = lk.sck;
    assign spi_mosi   = lk.mosi;
    assign spi_hold_n = lk.hold_n;
    assign spi_wp_n   = wp_r;

    // Input from the memory: three stages, change taken once two agree
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            miso_sync <= MISO_SYNC_RST;
            miso_f    <= 1'b1;
        end
        else
        begin
            miso_sync <= {miso_sync[1:0], spi_miso};
            if (miso_sync[1] == miso_sync[2])
                miso_f <= miso_sync[2];
        end
    end

    assign lk.miso_f    = miso_f;
    assign lk.pause_req = pause_r;

    // Bus slave decode
    wire busy    = (state != M_IDLE);
    wire wr_acc  = av_write && !av_waitrequest;
    wire rd_take = av_read && av_waitrequest;
    wire sel_ctl = (av_address == REG_CTRL);
    wire sel_adr = (av_address == REG_ADDR);
    wire sel_len = (av_address == REG_LEN);
    wire sel_sts = (av_address == REG_STAT);
    wire sel_dat = (av_address == REG_DATA);
    wire sel_pin = (av_address == REG_PINS);

    // Command checks made at the go write
    wire [2:0]   new_cmd   = av_writedata[2:0];
    wire         go_fire   = wr_acc && sel_ctl && av_writedata[CTRL_GO_BIT] && !busy;
    wire         new_addr  = (new_cmd == CMD_READ) || (new_cmd == CMD_WRITE);
    wire [6:0]   page_end  = 7'(addr_r[PTR_W-1:0]) + 7'(len_r);
    wire         len_ok    = (len_r != '0) && (7'(len_r) <= 7'(BUF_DEPTH));
    wire         page_ok   = page_end <= 7'(BUF_DEPTH);
    wire         bad_req   = (new_cmd > CMD_STAT_WR) || (new_addr && !len_ok) ||
                             ((new_cmd == CMD_WRITE) && !page_ok);
    wire         go_ok     = go_fire && !bad_req;

    // Byte sequencing
    wire opc_only = (cmd_r == CMD_LATCH_SET) || (cmd_r == CMD_LATCH_CLR);
    wire addr_cmd = (cmd_r == CMD_READ) || (cmd_r == CMD_WRITE);
    wire is_last  = ((state == M_OPC) && opc_only) ||
                    ((state == M_DATA) && (!addr_cmd || (nbyte == LEN_W'(len_r - 1'b1))));
    wire seq_done = lk.done && is_last;
    wire wr_kind  = (cmd_r == CMD_WRITE) || (cmd_r == CMD_STAT_WR);
    wire dev_busy = lk.rx[DEV_BUSY_BIT];
    wire poll_go  = seq_done && ((wr_kind && poll_en) || (polling && (cmd_r == CMD_STAT_RD) && dev_busy));
    wire cap_rx   = lk.done && (state == M_DATA) && ((cmd_r == CMD_READ) || (cmd_r == CMD_STAT_RD));

    wire [7:0] opcode = (cmd_r == CMD_READ)      ? OP_READ :
                        (cmd_r == CMD_WRITE)     ? OP_WRITE :
                        (cmd_r == CMD_LATCH_SET) ? OP_LATCH_SET :
                        (cmd_r == CMD_LATCH_CLR) ? OP_LATCH_CLR :
                        (cmd_r == CMD_STAT_RD)   ? OP_STATUS_RD :
                                                   OP_STATUS_WR;

    wire [7:0] addr_hi = {{ADDR_PAD{1'b0}}, addr_r[ADDR_W-1:8]};

    wire [7:0] tx_byte = (state == M_OPC)  ? opcode :
                         (state == M_ADDH) ? addr_hi :
                         (state == M_ADDL) ? addr_r[7:0] :
                         wr_kind           ? buf_mem[nbyte[PTR_W-1:0]] :
                                             8'h00;

    wire sec_seq_e next_state = (state == M_OPC)  ? (opc_only ? M_IDLE : (addr_cmd ? M_ADDH : M_DATA)) :
                                (state == M_ADDH) ? M_ADDL :
                                (state == M_ADDL) ? M_DATA :
                                is_last           ? M_IDLE :
                                                    M_DATA;

    assign lk.start = start;
    assign lk.tx    = tx_byte;
    assign lk.last  = is_last;

    // Sequencer
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state   <= M_IDLE;
            cmd_r   <= CMD_READ;
            nbyte   <= '0;
            start   <= 1'b0;
            err     <= 1'b0;
            polling <= 1'b0;
        end
        else
        begin
            start <= 1'b0;
            if (go_fire)
            begin
                err <= bad_req;
                if (!bad_req)
                begin
                    cmd_r   <= new_cmd;
                    state   <= M_OPC;
                    nbyte   <= '0;
                    polling <= 1'b0;
                    start   <= 1'b1;
                end
            end
            else if (poll_go)
            begin
                // Reissue a status read until the write cycle ends
                cmd_r   <= CMD_STAT_RD;
                state   <= M_OPC;
                nbyte   <= '0;
                polling <= 1'b1;
                start   <= 1'b1;
            end
            else if (lk.done)
            begin
                state <= next_state;
                start <= !is_last;
                if (state == M_DATA)
                    nbyte <= nbyte + 1'b1;
                if (seq_done)
                    polling <= 1'b0;
            end
        end
    end

    // Software registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            addr_r    <= '0;
            len_r     <= LEN_RST;
            poll_en   <= 1'b0;
            pause_r   <= 1'b0;
            wp_r      <= WP_RST;
            wptr      <= '0;
            rptr      <= '0;
            stat_byte <= 8'h00;
        end
        else
        begin
            if (go_fire)
                poll_en <= av_writedata[CTRL_POLL_BIT];
            if (wr_acc && sel_adr && !busy)
                addr_r <= av_writedata[ADDR_W-1:0];
            if (wr_acc && sel_len && !busy)
                len_r <= av_writedata[LEN_W-1:0];
            if (wr_acc && sel_pin)
            begin
                pause_r <= av_writedata[PINS_PAUSE_BIT];
                wp_r    <= av_writedata[PINS_WP_BIT];
            end
            if (go_ok)
                wptr <= '0;
            else if (wr_acc && sel_dat && !busy)
                wptr <= wptr + 1'b1;
            if (go_ok)
                rptr <= '0;
            else if (rd_take && sel_dat)
                rptr <= rptr + 1'b1;
            if (cap_rx && (cmd_r == CMD_STAT_RD))
                stat_byte <= lk.rx;
        end
    end

    // Shared data buffer; bus fills it only while idle
    always_ff @(posedge core_clk)
    begin
        if (wr_acc && sel_dat && !busy)
            buf_mem[wptr] <= av_writedata[7:0];
        else if (cap_rx)
            buf_mem[nbyte[PTR_W-1:0]] <= lk.rx;
    end

    // Read data and one-cycle wait state
    wire [31:0] stat_word = {16'h0000, stat_byte, 5'h00, stat_byte[DEV_BUSY_BIT], err, busy};
    wire [31:0] pins_word = {29'h0000_0000, lk.hold_n, wp_r, pause_r};
    wire [31:0] rd_word   = sel_ctl ? {22'h00_0000, poll_en, 6'h00, cmd_r} :
                            sel_adr ? 32'(addr_r) :
                            sel_len ? 32'(len_r) :
                            sel_sts ? stat_word :
                            sel_dat ? 32'(buf_mem[rptr]) :
                            sel_pin ? pins_word :
                                      32'h0000_0000;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            av_waitrequest <= 1'b1;
            av_readdata    <= 32'h0000_0000;
        end
        else
        begin
            av_waitrequest <= !((av_read || av_write) && av_waitrequest);
            if (rd_take)
                av_readdata <= rd_word;
        end
    end

    sequence s_take;
        lk.start && lk.idle;
    endsequence

    sequence s_last_byte;
        lk.start && lk.idle && lk.last;
    endsequence

    a_hold_high: assert property (@(posedge core_clk) disable iff (rst)
        !pause_r && !$past(pause_r) |-> spi_hold_n)
        else $error("pause pin low without a pause request");

    a_hold_fall: assert property (@(posedge core_clk) disable iff (rst)
        $fell(spi_hold_n) |-> !spi_sck && !spi_cs_n)
        else $error("pause asserted with clock high or deselected");

    a_pause_quiet: assert property (@(posedge core_clk) disable iff (rst)
        !spi_hold_n |=> !spi_cs_n && $stable(spi_sck) && $stable(spi_mosi))
        else $error("link moved or deselected during pause");

    a_hold_rise: assert property (@(posedge core_clk) disable iff (rst)
        $rose(spi_hold_n) |-> !spi_sck [*4])
        else $error("pause released near a clock rise");

    a_frame_whole: assert property (@(posedge core_clk) disable iff (rst)
        $rose(spi_sck) |-> !spi_cs_n && spi_hold_n)
        else $error("clock edge outside a selected, unpaused frame");

    a_msb_first: assert property (@(posedge core_clk) disable iff (rst)
        s_take |=> spi_mosi == $past(lk.tx[7]))
        else $error("first bit out is not the most significant");

    a_read_opcode: assert property (@(posedge core_clk) disable iff (rst)
        lk.start && (state == M_OPC) && (cmd_r == CMD_READ) |-> lk.tx == OP_READ)
        else $error("read opcode wrong");

    a_addr_top: assert property (@(posedge core_clk) disable iff (rst)
        lk.start && (state == M_ADDH) |-> lk.tx[7:5] == 3'h0 && lk.tx[4:0] == addr_r[ADDR_W-1:8])
        else $error("address high byte wrong");

    a_read_end: assert property (@(posedge core_clk) disable iff (rst)
        $fell(busy) |-> spi_cs_n && spi_hold_n)
        else $error("sequence finished while still selected");

    a_latch_alone: assert property (@(posedge core_clk) disable iff (rst)
        lk.start && (state == M_OPC) && (cmd_r == CMD_LATCH_SET) |-> lk.last && lk.tx == OP_LATCH_SET)
        else $error("latch set not closed after its eighth bit");

    a_page_refuse: assert property (@(posedge core_clk) disable iff (rst)
        go_fire && (new_cmd == CMD_WRITE) && !page_ok |=> (state == M_IDLE) && err && spi_cs_n)
        else $error("page-crossing write was started");

    a_write_end: assert property (@(posedge core_clk) disable iff (rst)
        s_last_byte |-> ##[1:700] (lk.done && spi_cs_n))
        else $error("select not raised after the final byte");

    a_status_ops: assert property (@(posedge core_clk) disable iff (rst)
        lk.start && (state == M_OPC) && (cmd_r == CMD_LATCH_CLR || cmd_r == CMD_STAT_WR)
        |-> lk.tx == ((cmd_r == CMD_LATCH_CLR) ? OP_LATCH_CLR : OP_STATUS_WR))
        else $error("latch clear or status write opcode wrong");
endmodule : sec_host

// ### testbench/sec_mem.sv
// Behavioural serial memory answering the host controller
module sec_mem
    import sec_pkg::*;
#(
    parameter int BUSY_CYC = 300
)
(
    input wire logic core_clk,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    output logic     miso,
    input wire logic hold_n,
    input wire logic wp_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [8192];
    logic [7:0]  pbuf [32];
    logic [31:0] pm;
    logic [7:0]  sr, op, ob, nst, st;
    logic [12:0] a;
    logic        ob7, drv;
    int          cnt, busy;
    wire         live = !cs_n && hold_n;
    // Released line shows the inverse so a stale bit never passes
    assign miso = (live && drv) ? ob7 : !ob7;
    function automatic logic prot(input logic [12:0] x);
        return st[3:2] == 2'b11 || (st[3] && x[12]) || (st[2] && x[12:11] == 2'b11);
    endfunction : prot
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hFF;
        st = 8'h00;
        busy = 0;
        {ob7, ob} = 9'h000;
        drv = 1'b0;
    end
    always @(posedge core_clk) if (busy > 0) busy = busy - 1;
    always @(negedge cs_n)
    begin
        cnt = 0;
        op = 8'h00;
        pm = 32'h0;
        drv = 1'b0;
    end
    always @(posedge sck) if (live)
    begin
        sr = {sr[6:0], mosi};
        cnt = cnt + 1;
        if (cnt % 8 == 0)
        begin
            if (cnt == 8) op = sr;
            if (cnt == 16) a[12:8] = sr[4:0];
            if (cnt == 16) nst = sr;
            if (cnt == 24) a[7:0] = sr;
            if (op == OP_STATUS_RD) ob = {st[7:1], busy != 0};
            if (op == OP_READ && cnt >= 24) ob = busy != 0 ? 8'h00 : mem[a];
            if (op == OP_READ && cnt >= 24) a = a + 13'h1;
            if (op == OP_WRITE && cnt >= 32) pbuf[a[4:0]] = sr;
            if (op == OP_WRITE && cnt >= 32) pm[a[4:0]] = 1'b1;
            if (op == OP_WRITE && cnt >= 32) a[4:0] = a[4:0] + 5'h1;
            drv = (op == OP_READ && cnt >= 24) || op == OP_STATUS_RD;
        end
    end
    always @(negedge sck) if (live)
    begin
        ob7 = ob[7];
        ob = {ob[6:0], 1'b0};
    end
    always @(posedge cs_n)
    begin
        drv = 1'b0;
        if (cnt == 8 && op == OP_LATCH_SET) st[1] = 1'b1;
        if (cnt == 8 && op == OP_LATCH_CLR) st[1] = 1'b0;
        if (cnt == 16 && op == OP_STATUS_WR && st[1] && (wp_n || !st[7]) && busy == 0)
        begin
            st = {nst[7], 3'b000, nst[3:2], 2'b00};
            busy = BUSY_CYC;
        end
        if (cnt >= 32 && cnt % 8 == 0 && op == OP_WRITE && st[1] && busy == 0)
        begin
            for (int i = 0; i < 32; i++)
                if (pm[i] && !prot({a[12:5], 5'(i)})) mem[{a[12:5], 5'(i)}] = pbuf[i];
            st[1] = 1'b0;
            busy = BUSY_CYC;
        end
    end
endmodule : sec_mem

// ### testbench/tb_sec_host.sv
// Self-checking bench for the serial memory host controller
module tb_sec_host import sec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst, av_read, av_write, av_waitrequest, ph;
    logic        spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_hold_n, spi_wp_n;
    logic [7:0]  av_address, d [4];
    logic [31:0] av_writedata, av_readdata, rdat, exp_q [$], msk_q [$];
    string       nm_q [$];
    int          failures, n_compared, seed;
    sec_host #(.HALF_CYC(5), .GAP_CYC(4)) u_dut (.core_clk(core_clk), .rst(rst), .av_address(av_address),
        .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata), .av_readdata(av_readdata),
        .av_waitrequest(av_waitrequest), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n));
    sec_mem u_mem (.core_clk(core_clk), .cs_n(spi_cs_n), .sck(spi_sck), .mosi(spi_mosi), .miso(spi_miso),
        .hold_n(spi_hold_n), .wp_n(spi_wp_n));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = !core_clk;
    end
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic hang();
        failures++;
        stop_test();
    endtask : hang
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic take();
        logic [31:0] e, m;
        string       s;
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        s = nm_q.pop_front();
        if (m !== 32'h0)
            chk(s, e, av_readdata & m);
    endtask : take
    // Sampling on the falling edge keeps clear of the slave's own updates
    always @(negedge core_clk)
    begin
        if (av_read === 1'b1 && av_waitrequest === 1'b0 && msk_q.size() > 0)
            take();
        if (spi_hold_n !== ph || spi_hold_n !== 1'b1)
            chk("pause_sck_cs", 32'h0, {30'h0, spi_sck, spi_cs_n});
        ph = spi_hold_n;
    end
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge core_clk);
        av_address   <= a;
        av_write     <= w;
        av_read      <= !w;
        av_writedata <= v;
        do
            @(posedge core_clk);
        while (av_waitrequest !== 1'b0 && ++n < 100);
        if (n >= 100)
            hang();
        rdat = av_readdata;
        av_write <= 1'b0;
        av_read  <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(a, 1'b1, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string s);
        exp_q.push_back(e);
        msk_q.push_back(m);
        nm_q.push_back(s);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    task automatic idle();
        int n;
        n = 0;
        do
            rd(REG_STAT, 32'h0, 32'h0, "poll");
        while (rdat[0] !== 1'b0 && ++n < 4000);
        if (n >= 4000)
            hang();
    endtask : idle
    task automatic op(input logic [2:0] c, input logic [12:0] a, input logic [5:0] l, input logic p);
        wr(REG_ADDR, {19'h0, a});
        wr(REG_LEN, {26'h0, l});
        wr(REG_CTRL, {22'h0, p, 1'b1, 5'h0, c});
        idle();
    endtask : op
    task automatic srd(input logic [31:0] e, input string s);
        op(CMD_STAT_RD, 13'h0, 6'h1, 1'b0);
        rd(REG_DATA, e, 32'hFF, s);
    endtask : srd
    task automatic wen();
        op(CMD_LATCH_SET, 13'h0, 6'h1, 1'b0);
    endtask : wen
    initial
    begin
        logic [7:0]  ra [6];
        logic [31:0] rv [6];
        ra = '{REG_CTRL, REG_ADDR, REG_LEN, REG_STAT, REG_PINS, 8'h40};
        rv = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h6, 32'h0};
        seed = 32'hA345;
        {failures, n_compared} = 64'h0;
        {ph, rst, av_read, av_write, av_address, av_writedata} = {2'b11, 42'h0};
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
            rd(ra[i], rv[i], 32'hFFFF_FFFF, "reset_value");
        $display("done reset values");
        srd(32'h0, "status_idle");
        wen();
        srd(32'h2, "latch_set");
        op(CMD_LATCH_CLR, 13'h0, 6'h1, 1'b0);
        srd(32'h0, "latch_clear");
        wr(REG_ADDR, 32'h1FFE);
        wr(REG_LEN, 32'h4);
        wr(REG_CTRL, 32'h101);
        rd(REG_STAT, 32'h2, 32'h3, "page_cross_refused");
        $display("done latch and status");
        for (int i = 0; i < 4; i++)
            d[i] = 8'($random(seed));
        wen();
        for (int i = 0; i < 4; i++)
            wr(REG_DATA, {24'h0, d[i]});
        op(CMD_WRITE, 13'h1FFC, 6'h4, 1'b1);
        rd(REG_STAT, 32'h0, 32'hFF01, "status_after_write");
        for (int i = 0; i < 4; i++)
            wr(REG_DATA, {24'h0, ~d[i]});
        op(CMD_WRITE, 13'h1FFC, 6'h4, 1'b1);
        op(CMD_READ, 13'h1FFC, 6'h8, 1'b0);
        for (int i = 0; i < 8; i++)
            rd(REG_DATA, i < 4 ? {24'h0, d[i[1:0]]} : 32'hFF, 32'hFF, "read_wrap");
        $display("done page write");
        wen();
        wr(REG_DATA, 32'h8C);
        op(CMD_STAT_WR, 13'h0, 6'h1, 1'b1);
        srd(32'h8C, "block_protect_set");
        wen();
        wr(REG_DATA, 32'h12);
        op(CMD_WRITE, 13'h0, 6'h1, 1'b1);
        op(CMD_READ, 13'h0, 6'h1, 1'b0);
        rd(REG_DATA, 32'hFF, 32'hFF, "protected_byte");
        wr(REG_PINS, 32'h0);
        wen();
        wr(REG_DATA, 32'h0);
        op(CMD_STAT_WR, 13'h0, 6'h1, 1'b1);
        srd(32'h8E, "status_pin_guard");
        wr(REG_PINS, 32'h2);
        wr(REG_DATA, 32'h0);
        op(CMD_STAT_WR, 13'h0, 6'h1, 1'b1);
        srd(32'h0, "status_released");
        $display("done protection");
        wr(REG_ADDR, 32'h1FFC);
        wr(REG_LEN, 32'h4);
        wr(REG_CTRL, 32'h100);
        repeat (60) @(posedge core_clk);
        wr(REG_PINS, 32'h3);
        repeat (10) @(posedge core_clk);
        rd(REG_PINS, 32'h3, 32'h7, "hold_pin_low");
        repeat (40) @(posedge core_clk);
        wr(REG_PINS, 32'h2);
        idle();
        for (int i = 0; i < 4; i++)
            rd(REG_DATA, {24'h0, d[i]}, 32'hFF, "read_after_pause");
        $display("done pause");
        stop_test();
    end
endmodule : tb_sec_host
